// [pkg/async_port_pkg.sv]
// constants and types shared by the serial port control and status logic
package async_port_pkg;
  // register indexes; byte address is four times the index
  localparam logic [7:0] CTL_IDX = 8'h98;
  localparam logic [7:0] BUF_IDX = 8'h99;
  localparam logic [7:0] STAT_IDX = 8'ha0;
  localparam logic [7:0] MASK_IDX = 8'ha1;
  localparam logic [7:0] DIV_IDX = 8'ha2;
  // port_control field positions
  localparam int MODE_BIT = 7;
  localparam int RSVD_BIT = 6;
  localparam int CHK_BIT = 5;
  localparam int REN_BIT = 4;
  localparam int TX9_BIT = 3;
  localparam int RX9_BIT = 2;
  localparam int TDONE_BIT = 1;
  localparam int RDONE_BIT = 0;
  // reset values
  localparam logic [7:0] CTL_RST = 8'h40;
  localparam logic [7:0] BUF_RST = 8'h00;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam logic [15:0] DIV_RST = 16'h0021;
  localparam logic [2:0] LAST_DATA = 3'h7;
  // frame sequencer states, gray along start, data, ninth, stop
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_START = 3'h1,
    ST_DATA = 3'h3,
    ST_NINTH = 3'h2,
    ST_STOP = 3'h6
  } line_state_t;
endpackage

// [design/async_port.sv]
// asynchronous serial port with control, status, buffer and apb registers
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module async_port (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [9:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic rxd_in,
  output logic txd_out,
  output logic irq_out
);
  // sticky flag update: a hardware set beats a software write
  function automatic logic flag_next(input logic q, input logic set,
                                     input logic we, input logic wv);
    flag_next = set | (we ? wv : q);
  endfunction

  logic pready_q, pslverr_q, txd_q, irq_q;
  logic [31:0] prdata_q;
  logic mode_q, chk_en_q, ren_q, tx9_q, rx9_q, tdone_q, rdone_q;
  logic [1:0] stat_q, mask_q;
  logic [15:0] div_q, tx_cnt_q, rx_cnt_q;
  logic [7:0] tx_sh_q, rx_sh_q, rx_buf_q;
  logic [2:0] tx_bit_q, rx_bit_q;
  logic rx_m_q, rx_s_q, nin_q;
  async_port_pkg::line_state_t tx_st_q, rx_st_q;
  logic acc, wr, hit;
  logic [7:0] idx, ctl_rd;
  logic [31:0] rd_d;
  logic tx_tick, rx_tick, tx_set, rx_done, rx_qual, rx_acc;
  logic wr_ctl, wr_buf, wr_stat;

  // bus decode; a request completes on the edge that sees pready
  assign acc = psel_in & penable_in & pready_q;
  assign wr = acc & pwrite_in;
  assign idx = paddr_in[9:2];
  assign wr_ctl = wr && (idx == async_port_pkg::CTL_IDX);
  assign wr_buf = wr && (idx == async_port_pkg::BUF_IDX);
  assign wr_stat = wr && (idx == async_port_pkg::STAT_IDX);
  assign ctl_rd = {mode_q, 1'b1, chk_en_q, ren_q, tx9_q, rx9_q, tdone_q, rdone_q};

  // read mux
  always_comb begin
    hit = 1'b1;
    rd_d = 32'h0;
    if (idx == async_port_pkg::CTL_IDX) begin
      rd_d[7:0] = ctl_rd;
    end else if (idx == async_port_pkg::BUF_IDX) begin
      rd_d[7:0] = rx_buf_q;
    end else if (idx == async_port_pkg::STAT_IDX) begin
      rd_d[1:0] = stat_q;
    end else if (idx == async_port_pkg::MASK_IDX) begin
      rd_d[1:0] = mask_q;
    end else if (idx == async_port_pkg::DIV_IDX) begin
      rd_d[15:0] = div_q;
    end else begin
      hit = 1'b0;
    end
  end

  // one wait state: pready rises at the end of the first access cycle
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= psel_in & penable_in & ~pready_q;
      if (psel_in & penable_in & ~pready_q) begin
        prdata_q <= pwrite_in ? 32'h0 : rd_d;
        pslverr_q <= ~hit;
      end
    end
  end

  // baud ticks: a bit lasts div+1 cycles
  assign tx_tick = (tx_cnt_q == 16'h0);
  assign rx_tick = (rx_cnt_q == 16'h0);
  // 8-bit frame done after the eighth data bit
  // 9-bit frame done as the stop bit starts
  assign tx_set = tx_tick && (((tx_st_q == async_port_pkg::ST_DATA) &&
                  (tx_bit_q == async_port_pkg::LAST_DATA) && !mode_q) ||
                  (tx_st_q == async_port_pkg::ST_NINTH));
  // byte received at the stop bit sample
  assign rx_done = ren_q && rx_tick && (rx_st_q == async_port_pkg::ST_STOP);
  // ninth data bit in 9-bit mode
  assign rx_qual = mode_q ? nin_q : rx_s_q;
  // frame check off ignores the qualifier
  // 8-bit check on needs stop bit 1
  // 9-bit check on needs ninth bit 1
  assign rx_acc = rx_done && (!chk_en_q || rx_qual);

  // control bits; frame length select is bit 7
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      mode_q <= async_port_pkg::CTL_RST[async_port_pkg::MODE_BIT];
      chk_en_q <= async_port_pkg::CTL_RST[async_port_pkg::CHK_BIT];
      ren_q <= async_port_pkg::CTL_RST[async_port_pkg::REN_BIT];
      tx9_q <= async_port_pkg::CTL_RST[async_port_pkg::TX9_BIT];
      rx9_q <= async_port_pkg::CTL_RST[async_port_pkg::RX9_BIT];
    end else begin
      if (wr_ctl) begin
        mode_q <= pwdata_in[async_port_pkg::MODE_BIT];
        chk_en_q <= pwdata_in[async_port_pkg::CHK_BIT];
        ren_q <= pwdata_in[async_port_pkg::REN_BIT];
        tx9_q <= pwdata_in[async_port_pkg::TX9_BIT];
      end
      // hardware load of the ninth receive bit wins over software
      if (rx_acc) begin
        rx9_q <= rx_qual;
      end else if (wr_ctl) begin
        rx9_q <= pwdata_in[async_port_pkg::RX9_BIT];
      end
    end
  end

  // done flags clear only by software write
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      tdone_q <= async_port_pkg::CTL_RST[async_port_pkg::TDONE_BIT];
      rdone_q <= async_port_pkg::CTL_RST[async_port_pkg::RDONE_BIT];
    end else begin
      tdone_q <= flag_next(tdone_q, tx_set, wr_ctl, pwdata_in[async_port_pkg::TDONE_BIT]);
      rdone_q <= flag_next(rdone_q, rx_acc, wr_ctl, pwdata_in[async_port_pkg::RDONE_BIT]);
    end
  end

  // interrupt status is write-one-to-clear, mask enables each source
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      stat_q <= 2'h0;
      mask_q <= async_port_pkg::MASK_RST;
      div_q <= async_port_pkg::DIV_RST;
    end else begin
      stat_q[1] <= flag_next(stat_q[1], tx_set, wr_stat, stat_q[1] & ~pwdata_in[1]);
      stat_q[0] <= flag_next(stat_q[0], rx_acc, wr_stat, stat_q[0] & ~pwdata_in[0]);
      if (wr && (idx == async_port_pkg::MASK_IDX)) begin
        mask_q <= pwdata_in[1:0];
      end
      if (wr && (idx == async_port_pkg::DIV_IDX)) begin
        div_q <= pwdata_in[15:0];
      end
    end
  end

  // transmit events reach the interrupt line
  // receive events reach the interrupt line
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_q & mask_q);
    end
  end

  // transmit sequencer; a write while busy is dropped
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      tx_st_q <= async_port_pkg::ST_IDLE;
      txd_q <= 1'b1;
      tx_sh_q <= async_port_pkg::BUF_RST;
      tx_cnt_q <= 16'h0;
      tx_bit_q <= 3'h0;
    end else if (tx_st_q == async_port_pkg::ST_IDLE) begin
      if (wr_buf) begin
        tx_sh_q <= pwdata_in[7:0];
        txd_q <= 1'b0;
        tx_cnt_q <= div_q;
        tx_st_q <= async_port_pkg::ST_START;
      end
    end else if (!tx_tick) begin
      tx_cnt_q <= tx_cnt_q - 16'h1;
    end else begin
      tx_cnt_q <= div_q;
      case (tx_st_q)
        async_port_pkg::ST_START: begin
          txd_q <= tx_sh_q[0];
          tx_sh_q <= {1'b0, tx_sh_q[7:1]};
          tx_bit_q <= 3'h0;
          tx_st_q <= async_port_pkg::ST_DATA;
        end
        async_port_pkg::ST_DATA: begin
          if (tx_bit_q != async_port_pkg::LAST_DATA) begin
            txd_q <= tx_sh_q[0];
            tx_sh_q <= {1'b0, tx_sh_q[7:1]};
            tx_bit_q <= tx_bit_q + 3'h1;
          end else if (mode_q) begin
            // ninth bit from the live control bit
            txd_q <= tx9_q;
            tx_st_q <= async_port_pkg::ST_NINTH;
          end else begin
            txd_q <= 1'b1;
            tx_st_q <= async_port_pkg::ST_STOP;
          end
        end
        async_port_pkg::ST_NINTH: begin
          txd_q <= 1'b1;
          tx_st_q <= async_port_pkg::ST_STOP;
        end
        default: begin
          tx_st_q <= async_port_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // two-stage synchroniser on the line input
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      rx_m_q <= 1'b1;
      rx_s_q <= 1'b1;
    end else begin
      rx_m_q <= rxd_in;
      rx_s_q <= rx_m_q;
    end
  end

  // receive sequencer, samples mid-bit; a glitchy start is dropped
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      rx_st_q <= async_port_pkg::ST_IDLE;
      rx_cnt_q <= 16'h0;
      rx_bit_q <= 3'h0;
      rx_sh_q <= 8'h0;
      nin_q <= 1'b0;
    end else if (!ren_q) begin
      rx_st_q <= async_port_pkg::ST_IDLE;
    end else if (rx_st_q == async_port_pkg::ST_IDLE) begin
      if (!rx_s_q) begin
        rx_cnt_q <= {1'b0, div_q[15:1]};
        rx_st_q <= async_port_pkg::ST_START;
      end
    end else if (!rx_tick) begin
      rx_cnt_q <= rx_cnt_q - 16'h1;
    end else begin
      rx_cnt_q <= div_q;
      case (rx_st_q)
        async_port_pkg::ST_START: begin
          rx_bit_q <= 3'h0;
          rx_st_q <= rx_s_q ? async_port_pkg::ST_IDLE : async_port_pkg::ST_DATA;
        end
        async_port_pkg::ST_DATA: begin
          rx_sh_q <= {rx_s_q, rx_sh_q[7:1]};
          rx_bit_q <= rx_bit_q + 3'h1;
          if (rx_bit_q == async_port_pkg::LAST_DATA) begin
            rx_st_q <= mode_q ? async_port_pkg::ST_NINTH : async_port_pkg::ST_STOP;
          end
        end
        async_port_pkg::ST_NINTH: begin
          nin_q <= rx_s_q;
          rx_st_q <= async_port_pkg::ST_STOP;
        end
        default: begin
          rx_st_q <= async_port_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // receive latch only takes qualified frames
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      rx_buf_q <= async_port_pkg::BUF_RST;
    end else if (rx_acc) begin
      rx_buf_q <= rx_sh_q;
    end
  end

  assign prdata_out = prdata_q;
  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;
  assign txd_out = txd_q;
  assign irq_out = irq_q;

  // checks
  chk_off_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    rx_done && !chk_en_q |=> rdone_q) else $error("frame check off lost a frame");
  stop_check_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    rx_done && chk_en_q && !mode_q && !rx_s_q |=> !$rose(rdone_q))
    else $error("bad stop bit raised receive done");
  ninth_check_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    rx_done && chk_en_q && mode_q && !nin_q |=> !$rose(rdone_q))
    else $error("ninth bit 0 raised receive done");
  ren_off_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    !ren_q |=> rx_st_q == async_port_pkg::ST_IDLE) else $error("receiver ran while off");
  tx9_out_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    tx_st_q == async_port_pkg::ST_NINTH && tx_cnt_q == div_q |-> txd_q == tx9_q)
    else $error("ninth bit mismatch");
  rx9_load_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    rx_acc |=> rx9_q == $past(rx_qual)) else $error("ninth rx bit not loaded");
  tdone_set_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    $changed(tx_st_q) && tx_st_q == async_port_pkg::ST_STOP |-> tdone_q && txd_q)
    else $error("transmit done missing at stop bit");
  irq_path_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    tx_set && mask_q[1] |=> ##1 irq_out) else $error("interrupt not raised");
  flag_hold_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    rdone_q && !wr_ctl |=> rdone_q) else $error("receive done cleared by hardware");
  start_bit_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    wr_buf && tx_st_q == async_port_pkg::ST_IDLE |=> !txd_out [*2])
    else $error("no start bit after write");
  buf_read_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    psel_in && penable_in && !pready_q && !pwrite_in && idx == async_port_pkg::BUF_IDX
    |=> prdata_out[7:0] == $past(rx_buf_q)) else $error("buffer read not latch");
  nine_rx_c: cover property (@(posedge mclk_in) rx_acc && mode_q);
  eight_tx_c: cover property (@(posedge mclk_in) tx_set && !mode_q);
  reject_c: cover property (@(posedge mclk_in) rx_done && !rx_acc);
  irq_c: cover property (@(posedge mclk_in) $rose(irq_out));
endmodule // async_port
`default_nettype wire

// [tb/serial_peer.sv]
// remote serial peer: sends frames to the port and captures frames from it
`timescale 1ns/1ns
`default_nettype none
module serial_peer #(
  parameter int BIT_CYC = 4
) (
  input wire logic clk_in,
  input wire logic line_in,
  output logic line_out
);
  // idle line sits high, as its pull-up would hold it
  initial line_out = 1'b1;

  // start low, lsb first, stop last
  task automatic send(input logic [7:0] d, input logic nine, input logic ninth,
                      input logic stop);
    logic [10:0] bits;
    int n;
    bits = nine ? {stop, ninth, d, 1'b0} : {1'b1, stop, d, 1'b0};
    n = nine ? 11 : 10;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_in);
      line_out <= bits[i];
      repeat (BIT_CYC - 1) @(posedge clk_in);
    end
    @(posedge clk_in);
    line_out <= 1'b1;
    repeat (2 * BIT_CYC) @(posedge clk_in);
  endtask

  // mid-bit sampling of the port's frame
  task automatic capture(input logic nine, output logic [7:0] d, output logic ninth,
                         output logic stop, output logic ok);
    int cnt;
    cnt = 0;
    ok = 1'b0;
    d = 8'h00;
    ninth = 1'b0;
    stop = 1'b0;
    while (line_in !== 1'b0 && cnt < 400) begin
      @(posedge clk_in);
      cnt++;
    end
    if (line_in === 1'b0) begin
      repeat (BIT_CYC / 2) @(posedge clk_in);
      ok = (line_in === 1'b0);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge clk_in);
        d[i] = line_in;
      end
      if (nine) begin
        repeat (BIT_CYC) @(posedge clk_in);
        ninth = line_in;
      end
      repeat (BIT_CYC) @(posedge clk_in);
      stop = line_in;
    end
  endtask
endmodule // serial_peer
`default_nettype wire

// [tb/async_port_tb_top.sv]
// self-checking bench for the serial port registers, line and interrupt
`timescale 1ns/1ns
`default_nettype none
module async_port_tb_top;
  localparam int BIT_CYC = 4;
  localparam logic [7:0] CTL = async_port_pkg::CTL_IDX;
  localparam logic [7:0] BUF = async_port_pkg::BUF_IDX;
  localparam logic [7:0] STAT = async_port_pkg::STAT_IDX;
  localparam logic [7:0] MASK = async_port_pkg::MASK_IDX;
  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, rxd, txd, irq, er, c9, cs, cok;
  logic [7:0] cd;
  logic [7:0] latch = 8'h00;
  int err_count = 0;
  int tests_run = 0;

  // free-running 250 MHz clock
  always #2 mclk_in = ~mclk_in;

  async_port DUT (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .rxd_in(rxd),
    .txd_out(txd), .irq_out(irq));
  serial_peer #(.BIT_CYC(BIT_CYC)) peer (.clk_in(mclk_in), .line_in(txd), .line_out(rxd));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge mclk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge mclk_in);
    penable <= 1'b1;
    // no fixed wait count: only the watchdog ends a stuck transfer
    do begin
      @(posedge mclk_in);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    check(rd, exp);
  endtask

  // irq lags status by one cycle, so let it settle first
  task automatic irq_chk(input logic exp);
    repeat (3) @(posedge mclk_in);
    check(32'(irq), 32'(exp));
  endtask

  task automatic tx_chk(input logic mode, input logic tb8, input logic [7:0] d);
    wr(CTL, {24'h0, mode, 3'b101, tb8, 3'b000});
    fork
      peer.capture(mode, cd, c9, cs, cok);
      wr(BUF, {24'h0, d});
    join
    check(32'({cok, cd, cs}), 32'({1'b1, d, 1'b1}));
    if (mode) check(32'(c9), 32'(tb8));
    rd_chk(CTL, {24'h0, mode, 3'b101, tb8, 3'b010});
    check(32'(irq), 32'h1);
    wr(CTL, {24'h0, mode, 3'b101, tb8, 3'b000});
    wr(STAT, 32'h3);
    irq_chk(1'b0);
  endtask

  task automatic rx_chk(input logic mode, input logic frame_check_enable, input logic ninth,
                        input logic stop, input logic [7:0] d, input logic acc);
    logic b8;
    b8 = acc & (mode ? ninth : stop);
    wr(CTL, {24'h0, mode, 1'b1, frame_check_enable, 5'b10000});
    peer.send(d, mode, ninth, stop);
    rd_chk(CTL, {24'h0, mode, 1'b1, frame_check_enable, 2'b10, b8, 1'b0, acc});
    if (acc) latch = d;
    rd_chk(BUF, {24'h0, latch});
    check(32'(irq), 32'(acc));
    wr(STAT, 32'h3);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // watchdog: the whole run needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge mclk_in);
    err_count++;
    tally_and_finish();
  end

  initial begin
    repeat (10) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    rd_chk(CTL, 32'h40);
    rd_chk(BUF, 32'h0);
    rd_chk(STAT, 32'h0);
    rd_chk(MASK, 32'h0);
    rd_chk(async_port_pkg::DIV_IDX, 32'h21);
    rd_chk(8'h10, 32'h0);
    check(32'(er), 32'h1);
    $display("test reset values done");
    wr(async_port_pkg::DIV_IDX, 32'h3);
    wr(MASK, 32'h3);
    tx_chk(1'b0, 1'b1, 8'ha5);
    tx_chk(1'b1, 1'b1, 8'h3c);
    tx_chk(1'b1, 1'b0, 8'hc3);
    rd_chk(BUF, 32'h0);
    $display("test transmit done");
    rx_chk(1'b0, 1'b0, 1'b1, 1'b0, 8'h5a, 1'b1);
    rx_chk(1'b0, 1'b1, 1'b0, 1'b0, 8'h11, 1'b0);
    rx_chk(1'b0, 1'b1, 1'b0, 1'b1, 8'h96, 1'b1);
    rx_chk(1'b1, 1'b1, 1'b0, 1'b1, 8'h22, 1'b0);
    rx_chk(1'b1, 1'b1, 1'b1, 1'b1, 8'h69, 1'b1);
    rx_chk(1'b1, 1'b0, 1'b0, 1'b1, 8'hf0, 1'b1);
    $display("test receive done");
    wr(CTL, 32'h40);
    peer.send(8'h33, 1'b0, 1'b0, 1'b1);
    rd_chk(CTL, 32'h40);
    rd_chk(BUF, {24'h0, latch});
    $display("test receive disabled done");
    wr(CTL, 32'h50);
    peer.send(8'h81, 1'b0, 1'b0, 1'b1);
    rd_chk(STAT, 32'h1);
    wr(MASK, 32'h2);
    irq_chk(1'b0);
    wr(MASK, 32'h3);
    irq_chk(1'b1);
    rd_chk(CTL, 32'h55);
    wr(STAT, 32'h1);
    irq_chk(1'b0);
    $display("test interrupt mask done");
    tally_and_finish();
  end
endmodule // async_port_tb_top
`default_nettype wire
